// ===== core/ocl_pkg.sv
package ocl_pkg;
    // ==================================================
    // Clock
    localparam int CLK_MHZ = 250;
    // ==================================================
    // Register map (byte addresses)
    localparam int ADDR_W = 12;
    localparam logic [11:0] CONTROL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // ==================================================
    // Control fields
    localparam int EN_BIT = 7;
    localparam int LEB_HI = 6;
    localparam int LEB_LO = 5;
    localparam int THR_HI = 4;
    localparam int THR_LO = 0;
    localparam int LEB_W = LEB_HI - LEB_LO + 1;
    localparam int THR_W = THR_HI - THR_LO + 1;
    // ==================================================
    // Status fields
    localparam int ST_FLAG_BIT = 0;
    localparam int ST_TERM_BIT = 1;
    localparam int ST_BLANK_BIT = 2;
    localparam int ST_CMP_BIT = 3;
    localparam int ST_CLEAN_BIT = 4;
    // ==================================================
    // Blanking times in ns, codes 0 to 3
    localparam int LEB0_NS = 114;
    localparam int LEB1_NS = 213;
    localparam int LEB2_NS = 400;
    localparam int LEB3_NS = 780;
    // Least times round up to whole cycles
    localparam int LEB0_CYC = (LEB0_NS * CLK_MHZ + 999) / 1000;
    localparam int LEB1_CYC = (LEB1_NS * CLK_MHZ + 999) / 1000;
    localparam int LEB2_CYC = (LEB2_NS * CLK_MHZ + 999) / 1000;
    localparam int LEB3_CYC = (LEB3_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK_CNT_W = 8;
    // ==================================================
    // Trip threshold in mV
    localparam int THR_BASE_MV = 160;
    localparam int THR_STEP_MV = 15;
endpackage

// ===== core/ocl_sync2.sv
`timescale 1ns/10ps
module ocl_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            meta <= '0;
            q_out <= '0;
        end
        else
        begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule

// ===== core/ocl_blank_timer.sv
`timescale 1ns/10ps
module ocl_blank_timer
    import ocl_pkg::*;
#(
    parameter int CNT_W = ocl_pkg::BLANK_CNT_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic start_in,
    input wire logic [ocl_pkg::LEB_W-1:0] sel_in,
    // Status
    output logic blanking_out
);
    logic [CNT_W-1:0] count;

    // ==================================================
    // Blanking length lookup
    function automatic logic [CNT_W-1:0] blank_cycles(input logic [LEB_W-1:0] sel);
        case (sel)
            2'h0: blank_cycles = CNT_W'(LEB0_CYC);
            2'h1: blank_cycles = CNT_W'(LEB1_CYC);
            2'h2: blank_cycles = CNT_W'(LEB2_CYC);
            default: blank_cycles = CNT_W'(LEB3_CYC);
        endcase
    endfunction

    // ==================================================
    // Count down from each turn-on edge
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            count <= '0;
        else if (start_in)
            count <= blank_cycles(sel_in);
        else if (count != '0)
            count <= count - CNT_W'(1);
    end

    // Comparator is masked while the count runs or on the turn-on cycle itself
    assign blanking_out = start_in || (count != '0);
endmodule

// ===== core/ocl_top.sv
// How it works
// - Trips only count while high-side drive is on and comparator reports excess drop.
// - A trip sets the flag and drops the high-side drive on the next edge.
// - Drive returns at the next switching cycle start and is cut again if still tripping.
// - Hardware never clears the flag; software clears it by writing one.
// - A clear before a clean switching cycle sets the flag again at once.
// - Flag is set regardless of any interrupt enable.
// - Bits 6-5 pick blanking of 114, 213, 400 or 780 ns after turn-on.
// - Bits 4-0 pick the trip drop, 160 mV plus 15 mV per code.
// - Detection works only while bit 7 is set; it resets to zero.
`timescale 1ns/10ps
module ocl_top
    import ocl_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ocl_pkg::ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Modulator side
    input wire logic CYCLE_START_IN,
    input wire logic DRIVE_REQ_IN,
    // Current sense comparator pin
    input wire logic OC_COMPARE_IN,
    // Analog and driver side
    output logic HS_DRIVE_OUT,
    output logic OVERCURRENT_DETECT_ENABLE_OUT,
    output logic [ocl_pkg::THR_W-1:0] OVERCURRENT_THRESHOLD_CODE_OUT,
    output logic OVERCURRENT_FLAG_OUT
);
    import ocl_pkg::*;

    // ==================================================
    // Registers and internal state
    logic [7:0] overcurrent_control;
    logic overcurrent_flag;
    logic terminated;
    logic cycle_tripped;
    logic clean_cycle_seen;
    logic drive_prev;
    logic cmp_sync;
    logic blanking;
    logic trip;
    logic overcurrent_detect_enable;
    logic [LEB_W-1:0] blanking_time_select;
    logic [THR_W-1:0] overcurrent_threshold_code;
    logic access;
    logic wr_ctrl;
    logic wr_status;
    logic flag_clear;
    logic next_flag;
    logic next_drive;
    logic [31:0] next_rdata;
    logic next_err;

    assign overcurrent_detect_enable = overcurrent_control[EN_BIT];
    assign blanking_time_select = overcurrent_control[LEB_HI:LEB_LO];
    assign overcurrent_threshold_code = overcurrent_control[THR_HI:THR_LO];

    // ==================================================
    // Comparator pin crossing
    ocl_sync2 #(
        .WIDTH(1)
    ) u_cmp_sync (
        .clk_in(MCLK_IN),
        .rst_n_in(RST_N_IN),
        .d_in(OC_COMPARE_IN),
        .q_out(cmp_sync)
    );

    // ==================================================
    // Leading edge blanking
    ocl_blank_timer #(
        .CNT_W(BLANK_CNT_W)
    ) u_blank (
        .clk_in(MCLK_IN),
        .rst_n_in(RST_N_IN),
        .start_in(HS_DRIVE_OUT && !drive_prev),
        .sel_in(blanking_time_select),
        .blanking_out(blanking)
    );

    // ==================================================
    // Trip detection
    // Only judged while the switch conducts and the blanking has run out
    assign trip = overcurrent_detect_enable && HS_DRIVE_OUT && !blanking && cmp_sync;

    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            drive_prev <= 1'b0;
        end
        else
        begin
            drive_prev <= HS_DRIVE_OUT;
        end
    end

    // ==================================================
    // Drive gating
    // A trip latches the pulse off until the next cycle start
    // Set wins: a trip on the start edge must still hold the drive off all cycle
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            terminated <= 1'b0;
        end
        else if (trip)
        begin
            terminated <= 1'b1;
        end
        else if (CYCLE_START_IN)
        begin
            terminated <= 1'b0;
        end
    end

    // The trip cycle itself cuts the drive, so the pulse ends one edge after detection
    always_comb
    begin
        next_drive = DRIVE_REQ_IN && !trip && (CYCLE_START_IN || !terminated);
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            HS_DRIVE_OUT <= 1'b0;
        end
        else
        begin
            HS_DRIVE_OUT <= next_drive;
        end
    end

    // ==================================================
    // Clean cycle tracking
    // Cycle in progress has tripped at least once
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            cycle_tripped <= 1'b0;
        end
        else if (CYCLE_START_IN)
        begin
            cycle_tripped <= trip;
        end
        else if (trip)
        begin
            cycle_tripped <= 1'b1;
        end
    end

    // Reset counts as clean so a first clear is honoured
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            clean_cycle_seen <= 1'b1;
        end
        else if (trip)
        begin
            clean_cycle_seen <= 1'b0;
        end
        else if (CYCLE_START_IN)
        begin
            clean_cycle_seen <= !cycle_tripped;
        end
    end

    // ==================================================
    // Sticky overcurrent flag
    // Set wins over clear; an early clear is undone at once
    assign flag_clear = wr_status && PWDATA_IN[ST_FLAG_BIT];

    always_comb
    begin
        next_flag = overcurrent_flag;
        if (flag_clear)
            next_flag = !clean_cycle_seen;
        if (trip)
            next_flag = 1'b1;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            overcurrent_flag <= 1'b0;
        end
        else
        begin
            overcurrent_flag <= next_flag;
        end
    end

    // ==================================================
    // Status word packing
    function automatic logic [31:0] status_word(
        input logic flag,
        input logic term,
        input logic blank,
        input logic cmp,
        input logic clean
    );
        status_word = 32'h0000_0000;
        status_word[ST_FLAG_BIT] = flag;
        status_word[ST_TERM_BIT] = term;
        status_word[ST_BLANK_BIT] = blank;
        status_word[ST_CMP_BIT] = cmp;
        status_word[ST_CLEAN_BIT] = clean;
    endfunction

    // ==================================================
    // APB slave
    // One wait state keeps PREADY and PRDATA straight from flops
    assign access = PSEL_IN && PENABLE_IN && PREADY_OUT;
    assign wr_ctrl = access && PWRITE_IN && (PADDR_IN == CONTROL_ADDR);
    assign wr_status = access && PWRITE_IN && (PADDR_IN == STATUS_ADDR);

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (PADDR_IN)
            CONTROL_ADDR: next_rdata[7:0] = overcurrent_control;
            STATUS_ADDR: next_rdata = status_word(overcurrent_flag, terminated, blanking, cmp_sync,
                clean_cycle_seen);
            default: next_err = 1'b1;
        endcase
        if (PWRITE_IN)
            next_rdata = 32'h0000_0000;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            PREADY_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end
        else if (PSEL_IN && PENABLE_IN && !PREADY_OUT)
        begin
            PREADY_OUT <= 1'b1;
            PRDATA_OUT <= next_rdata;
            PSLVERR_OUT <= next_err;
        end
        else
        begin
            PREADY_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end
    end

    // ==================================================
    // Control register
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            overcurrent_control <= CONTROL_RESET;
        end
        else if (wr_ctrl)
        begin
            overcurrent_control <= PWDATA_IN[7:0];
        end
    end

    // ==================================================
    // Analog side outputs
    // Enable copy for the comparator and its DAC
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            OVERCURRENT_DETECT_ENABLE_OUT <= 1'b0;
        end
        else
        begin
            OVERCURRENT_DETECT_ENABLE_OUT <= overcurrent_detect_enable;
        end
    end

    // Threshold code drives the DAC: 160 mV plus 15 mV per step
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            OVERCURRENT_THRESHOLD_CODE_OUT <= '0;
        end
        else
        begin
            OVERCURRENT_THRESHOLD_CODE_OUT <= overcurrent_threshold_code;
        end
    end

    // Flag pin is loaded from the same next value, so it never lags the status bit
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            OVERCURRENT_FLAG_OUT <= 1'b0;
        end
        else
        begin
            OVERCURRENT_FLAG_OUT <= next_flag;
        end
    end
endmodule

// ===== tb/ocl_top_asserts.sv
`timescale 1ns/10ps
module ocl_top_asserts
    import ocl_pkg::*;
(
    // Clock, reset and bus
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ocl_pkg::ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic PREADY_OUT,
    // Drive path
    input wire logic CYCLE_START_IN,
    input wire logic HS_DRIVE_OUT,
    input wire logic OVERCURRENT_DETECT_ENABLE_OUT,
    input wire logic [ocl_pkg::THR_W-1:0] OVERCURRENT_THRESHOLD_CODE_OUT,
    input wire logic OVERCURRENT_FLAG_OUT
);
    logic [7:0] wd;
    wire cmt = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
    wire clr = cmt & (PADDR_IN == STATUS_ADDR) & PWDATA_IN[0];
    wire cw = cmt & (PADDR_IN == CONTROL_ADDR);
    wire fl = OVERCURRENT_FLAG_OUT;
    wire hs = HS_DRIVE_OUT;
    wire en = OVERCURRENT_DETECT_ENABLE_OUT;
    always_ff @(posedge MCLK_IN)
    begin
        if (cw)
        begin
            wd <= PWDATA_IN[7:0];
        end
    end
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ====
    // Checks
    a_trip_cut: assert property ($rose(fl) |-> !hs)
        else $error("drive not cut on trip");
    a_drive_only: assert property (!hs |=> !$rose(fl))
        else $error("trip while switch off");
    a_cycle_restart: assert property ($rose(hs) |-> $past(CYCLE_START_IN))
        else $error("drive rose outside cycle start");
    a_flag_sticky: assert property (fl && !clr |=> fl)
        else $error("flag dropped without clear");
    a_blank_mask: assert property ($rose(hs) |=> (!$rose(fl)) [*8])
        else $error("trip inside blanking");
    a_off_quiet: assert property (!en [*3] |-> !$rose(fl))
        else $error("trip while disabled");
    a_en_copy: assert property (cw |-> ##2 (en == wd[7]))
        else $error("enable out differs from write");
    a_thr_copy: assert property (cw |-> ##2 (OVERCURRENT_THRESHOLD_CODE_OUT == wd[4:0]))
        else $error("threshold out differs from write");
    c_trip: cover property ($rose(fl));
    c_clear: cover property (clr && fl);
    c_drive: cover property ($rose(hs));
endmodule
bind ocl_top ocl_top_asserts u_chk (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT), .CYCLE_START_IN(CYCLE_START_IN),
    .HS_DRIVE_OUT(HS_DRIVE_OUT), .OVERCURRENT_FLAG_OUT(OVERCURRENT_FLAG_OUT),
    .OVERCURRENT_DETECT_ENABLE_OUT(OVERCURRENT_DETECT_ENABLE_OUT),
    .OVERCURRENT_THRESHOLD_CODE_OUT(OVERCURRENT_THRESHOLD_CODE_OUT));

// ===== tb/ocl_switch_model.sv
`timescale 1ns/10ps
module ocl_switch_model
    import ocl_pkg::*;
(
    // Gate and settings
    input wire logic hs_in,
    input wire logic en_in,
    input wire logic [ocl_pkg::THR_W-1:0] code_in,
    // Switch drop in mV, set by the bench
    input wire logic [15:0] drop_mv_in,
    // Comparator pin
    output logic oc_out
);
    // No drop while the switch is off, so the comparator idles low
    assign oc_out = hs_in & en_in & (drop_mv_in > THR_BASE_MV + THR_STEP_MV * code_in);
endmodule

// ===== tb/cycle_overcurrent_limiter_tb_top.sv
`timescale 1ns/10ps
module cycle_overcurrent_limiter_tb_top;
    import ocl_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, cs = 0, req = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic prdy, perr, er, oc, hs, en, fl;
    logic [4:0] thr;
    logic [15:0] drop = 0;
    int num_errors = 0, samples_checked = 0, tick = 0, n;
    initial forever #2 clk = ~clk;
    ocl_top dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .CYCLE_START_IN(cs), .DRIVE_REQ_IN(req),
        .OC_COMPARE_IN(oc), .HS_DRIVE_OUT(hs), .OVERCURRENT_DETECT_ENABLE_OUT(en),
        .OVERCURRENT_THRESHOLD_CODE_OUT(thr), .OVERCURRENT_FLAG_OUT(fl));
    ocl_switch_model sw (.hs_in(hs), .en_in(en), .code_in(thr), .drop_mv_in(drop), .oc_out(oc));
    // ====
    // Shared tasks
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request held until ready is sampled; a settle step lets the commit land
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (prdy !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = perr;
        psel <= 0;
        pen <= 0;
        #1;
    endtask
    // Modulator: one start pulse, drive wanted from it on; drive counted once settled
    task automatic swc(input int len);
        n = 0;
        @(posedge clk);
        cs <= 1;
        req <= 1;
        @(posedge clk);
        cs <= 0;
        repeat (len)
        begin
            @(negedge clk);
            if (hs === 1'b1)
                n++;
        end
    endtask
    // ====
    // Scenarios
    task automatic t_regs();
        apb(0, CONTROL_ADDR, 0);
        chk(rd, CONTROL_RESET);
        apb(1, CONTROL_ADDR, 32'hFFFFFF3F);
        apb(0, CONTROL_ADDR, 0);
        chk(rd, 32'h3F);
        chk(thr, 5'h1F);
        apb(0, 12'h008, 0);
        chk(er, 1);
        drop <= 16'd700;
        swc(300);
        chk(n, 300);
        chk(fl, 0);
    endtask
    task automatic t_blank();
        int ns[4] = '{LEB0_NS, LEB1_NS, LEB2_NS, LEB3_NS};
        for (int c = 0; c < 4; c++)
        begin
            apb(1, CONTROL_ADDR, 32'h83 | (c << 5));
            // A pulse still open from before must trip and end ahead of the timed start
            repeat (8) @(posedge clk);
            swc(300);
            chk(n, (ns[c] * CLK_MHZ + 999) / 1000 + 2);
            chk(fl, 1);
            swc(300);
            chk(n, (ns[c] * CLK_MHZ + 999) / 1000 + 2);
        end
    endtask
    task automatic t_clear();
        apb(1, STATUS_ADDR, 1);
        apb(0, STATUS_ADDR, 0);
        chk(rd[0], 1);
        chk(rd[ST_CLEAN_BIT], 0);
        drop <= 0;
        swc(300);
        swc(300);
        chk(fl, 1);
        apb(1, STATUS_ADDR, 1);
        chk(fl, 0);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        t_regs();
        t_blank();
        t_clear();
        wrap_up();
    end
    // Whole run needs under 4000 cycles
    always @(posedge clk)
    begin
        tick++;
        if (tick == 9000)
        begin
            num_errors++;
            wrap_up();
        end
    end
endmodule
